// >>> design/lcdc_pkg.sv
// constants shared by the cache/dll clock control block
// assumes a 32-bit register port with byte offsets of one word each
package lcdc_pkg;
   localparam int DATA_W = 32;
   localparam int ADDR_W = 8;
   localparam int TAP_W  = 7;
   // register offsets
   localparam logic [7:0] OFF_CTRL   = 8'h00;
   localparam logic [7:0] OFF_CONFIG = 8'h04;
   localparam logic [7:0] OFF_STATUS = 8'h08;
   // control fields (bit 0 of the big-endian numbering is bit 31 here)
   localparam int CTRL_ENABLE_BIT = 31;
   localparam int CTRL_DO_BIT     = 22;
   localparam int CTRL_ZZ_BIT     = 20;
   localparam int CTRL_IO_BIT     = 10;
   localparam int CTRL_CS_BIT     = 9;
   localparam int CTRL_DRO_BIT    = 8;
   localparam int CTRL_TAP_LSB    = 1;
   localparam int CTRL_IP_BIT     = 0;
   localparam logic [31:0] CTRL_WR_MASK = 32'h8050_0700;
   localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;
   // config fields
   localparam int CFG_BUS32_BIT   = 0;
   localparam int CFG_APCHK_BIT   = 1;
   localparam int CFG_DPCHK_BIT   = 2;
   localparam int CFG_PGEN_BIT    = 3;
   localparam int CFG_INVAL_BIT   = 4;
   localparam logic [3:0] CFG_RESET = 4'h0;
   // status fields
   localparam int STS_CKSTP_BIT   = 0;
   localparam int STS_NODRTRY_BIT = 1;
   localparam int STS_LOWPWR_BIT  = 2;
   // dll and invalidate figures
   localparam logic [6:0] TAP_LAST    = 7'h7F;
   localparam int         INVAL_LINES = 1024;
   localparam int         INVAL_W     = 10;
endpackage

// >>> design/lcdc_sync.sv
// two-flop synchroniser for levels entering the core clock domain
// assumes each bit is an independent level; no bus coherency implied
module lcdc_sync #(
   parameter int          W   = 1,
   parameter logic [W-1:0] RST = '0
) (
   input  wire logic         i_core_clk,
   input  wire logic         i_rst_n,
   input  wire logic [W-1:0] i_async,
   output logic      [W-1:0] o_sync
);
   logic [W-1:0] meta_r;

   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         meta_r <= RST;
         o_sync <= RST;
      end else begin
         meta_r <= i_async;
         o_sync <= meta_r;
      end
   end
endmodule

// >>> design/lcdc_inval.sv
// global invalidate sequencer: walks every line index once
// assumes the start pulse comes from the register port on the core clock
module lcdc_inval
   import lcdc_pkg::*;
(
   input  wire logic               i_core_clk,
   input  wire logic               i_rst_n,
   input  wire logic               i_start,
   output logic                    o_busy,
   output logic [INVAL_W-1:0]      o_index
);
   logic [INVAL_W-1:0] last_idx;
   assign last_idx = INVAL_W'(INVAL_LINES - 1);

   // a start while busy is ignored so the walk always completes
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_busy  <= 1'b0;
         o_index <= '0;
      end else if (!o_busy) begin
         o_busy  <= i_start;
         o_index <= '0;
      end else if (o_index == last_idx) begin
         o_busy  <= 1'b0;
      end else begin
         o_index <= o_index + INVAL_W'(1);
      end
   end
endmodule

// >>> design/lcdc_top.sv
// second-level cache control register, dll clock gating and bus pins
// assumes the dll clock, tap value and hard reset are asynchronous pins;
// power-mode and access requests come from core-clock logic
//
// Contract
// - io mode: data hits still use cache
// - io mode: data misses bypass, no allocate
// - do and io together lock the cache
// - io bit writable at any time
// - clock-stop halts sram clocks in nap/sleep
// - feedback clock keeps running while gated
// - rollover with enable forces checkstop
// - last tap counts as potential rollover
// - tap counter readable, sampled on read
// - lsb shows invalidate in progress
// - 32-bit mode: unused lanes off, zero
// - parity check off disables parity receivers
// - data receivers off outside reads
// - address receivers always sampling for snoop
// - zz auto asserts sleep pin in nap
module lcdc_top (
   input  wire logic                          i_core_clk,
   input  wire logic                          i_rst_n,
   // register port
   input  wire logic [lcdc_pkg::ADDR_W-1:0]   i_addr,
   input  wire logic [lcdc_pkg::DATA_W-1:0]   i_wdata,
   input  wire logic                          i_wr,
   input  wire logic                          i_rd,
   output logic      [lcdc_pkg::DATA_W-1:0]   o_rdata,
   // power mode from the core
   input  wire logic                          i_nap_sleep,
   input  wire logic                          i_snoop_wake,
   // cache access lookup
   input  wire logic                          i_acc_valid,
   input  wire logic                          i_acc_data,
   input  wire logic                          i_acc_write,
   input  wire logic                          i_acc_hit,
   output logic                               o_acc_valid,
   output logic                               o_acc_use_cache,
   output logic                               o_acc_allocate,
   output logic                               o_acc_inhibit,
   // dll pins
   input  wire logic                          i_dll_clk,
   input  wire logic [lcdc_pkg::TAP_W-1:0]    i_dll_tap_counter,
   output logic                               o_sram_clock_out,
   output logic                               o_dll_feedback_path,
   output logic                               o_sram_sleep_pin,
   output logic                               o_checkstop_out_n_o,
   output logic                               o_checkstop_out_n_oe_n,
   // reset and retry straps
   input  wire logic                          i_hard_reset_n,
   input  wire logic                          i_data_retry_n,
   output logic                               o_no_data_retry_mode,
   // system bus data and parity
   input  wire logic                          i_read_active,
   input  wire logic                          i_drive_en,
   input  wire logic [31:0]                   i_data_high_src,
   input  wire logic [31:0]                   i_data_low_src,
   input  wire logic [7:0]                    i_data_parity_src,
   output logic      [31:0]                   o_data_high_o,
   output logic      [31:0]                   o_data_low_o,
   output logic      [7:0]                    o_data_parity_o,
   output logic                               o_data_high_oe_n,
   output logic                               o_data_low_oe_n,
   output logic                               o_data_high_rx_en,
   output logic                               o_data_low_rx_en,
   output logic      [7:0]                    o_data_parity_rx_en,
   output logic                               o_addr_parity_rx_en,
   output logic                               o_snoop_rx_en,
   output logic                               o_cache_enable_bit
);
   import lcdc_pkg::*;

   logic [31:0]      ctrl_r;
   logic [31:0]      ctrl_nxt;
   logic [3:0]       cfg_r;
   logic             ckstp_r;
   logic             inval_busy;
   logic [TAP_W-1:0] tap_s;
   logic             dll_clk_s;
   logic             hard_reset_n_s;
   logic             dretry_s;
   logic             lowpower_r;

   // sync pins into the core clock domain
   lcdc_sync #(.W(TAP_W), .RST('0)) u_tap_sync (
      .i_core_clk (i_core_clk),
      .i_rst_n    (i_rst_n),
      .i_async    (i_dll_tap_counter),
      .o_sync     (tap_s)
   );

   lcdc_sync #(.W(3), .RST(3'b111)) u_pin_sync (
      .i_core_clk (i_core_clk),
      .i_rst_n    (i_rst_n),
      .i_async    ({i_dll_clk, i_hard_reset_n, i_data_retry_n}),
      .o_sync     ({dll_clk_s, hard_reset_n_s, dretry_s})
   );

   // register decode
   wire sel_ctrl = (i_addr == OFF_CTRL);
   wire sel_cfg  = (i_addr == OFF_CONFIG);
   wire sel_sts  = (i_addr == OFF_STATUS);
   wire wr_ctrl  = i_wr & sel_ctrl;
   wire wr_cfg   = i_wr & sel_cfg;
   wire inval_go = wr_cfg & i_wdata[CFG_INVAL_BIT];

   // only writable bits change; tap and pending bits are never stored
   assign ctrl_nxt = wr_ctrl ? (i_wdata & CTRL_WR_MASK) : ctrl_r;

   // io bit lands on the next edge, no disable needed first
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ctrl_r <= CTRL_RESET;
      end else begin
         ctrl_r <= ctrl_nxt;
      end
   end

   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cfg_r <= CFG_RESET;
      end else if (wr_cfg) begin
         cfg_r <= i_wdata[3:0];
      end
   end

   wire io_en    = ctrl_r[CTRL_IO_BIT];
   wire do_en    = ctrl_r[CTRL_DO_BIT];
   wire cs_en    = ctrl_r[CTRL_CS_BIT];
   wire zz_en    = ctrl_r[CTRL_ZZ_BIT];
   wire dro_en   = ctrl_r[CTRL_DRO_BIT];
   wire l2_on    = ctrl_r[CTRL_ENABLE_BIT];
   wire bus32    = cfg_r[CFG_BUS32_BIT];
   wire apchk    = cfg_r[CFG_APCHK_BIT];
   wire dpchk    = cfg_r[CFG_DPCHK_BIT];

   // invalidate walk
   lcdc_inval u_inval (
      .i_core_clk (i_core_clk),
      .i_rst_n    (i_rst_n),
      .i_start    (inval_go),
      .o_busy     (inval_busy),
      .o_index    ()
   );

   // read mux; the tap value is whatever is seen in the read cycle,
   // so bits may straddle a change and software must reread
   wire [31:0] ctrl_view = {ctrl_r[31:8],
                            tap_s,
                            inval_busy};
   wire [31:0] cfg_view  = {28'h0000000, cfg_r};
   wire [31:0] sts_view  = {29'h00000000,
                            lowpower_r,
                            o_no_data_retry_mode,
                            ckstp_r};
   wire [31:0] rd_mux    = sel_ctrl ? ctrl_view :
                           sel_cfg  ? cfg_view  :
                           sel_sts  ? sts_view  : 32'h0000_0000;

   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_rdata <= 32'h0000_0000;
      end else begin
         o_rdata <= i_rd ? rd_mux : 32'h0000_0000;
      end
   end

   // access steering
   wire locked    = io_en & do_en;
   wire data_miss = i_acc_data & ~i_acc_hit;
   wire bypass    = l2_on & io_en & data_miss;
   // only a hit is serviced; a miss goes out, allocating or not
   wire use_c     = l2_on & i_acc_hit;
   // do mode keeps instruction misses out, io mode data misses
   wire alloc_ok  = ~locked & ~(io_en & i_acc_data) &
                    ~(do_en & ~i_acc_data);
   wire alloc     = l2_on & ~i_acc_hit & alloc_ok;

   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_acc_valid     <= 1'b0;
         o_acc_use_cache <= 1'b0;
         o_acc_allocate  <= 1'b0;
         o_acc_inhibit   <= 1'b0;
      end else begin
         o_acc_valid     <= i_acc_valid;
         o_acc_use_cache <= i_acc_valid & use_c & ~bypass;
         o_acc_allocate  <= i_acc_valid & alloc;
         o_acc_inhibit   <= i_acc_valid & bypass;
      end
   end

   // power mode; a snoop wake counts as a temporary exit
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         lowpower_r <= 1'b0;
      end else begin
         lowpower_r <= i_nap_sleep & ~i_snoop_wake;
      end
   end

   // clocks follow the sampled dll clock; the gate only touches the
   // sram clock so the feedback loop and dll lock are undisturbed
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_sram_clock_out    <= 1'b0;
         o_dll_feedback_path <= 1'b0;
         o_sram_sleep_pin    <= 1'b0;
      end else begin
         o_sram_clock_out    <= dll_clk_s & ~(cs_en & lowpower_r);
         o_dll_feedback_path <= dll_clk_s;
         o_sram_sleep_pin    <= zz_en & lowpower_r;
      end
   end

   // checkstop is sticky until reset; software arms it any time
   wire at_last_tap = (tap_s == TAP_LAST);
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ckstp_r <= 1'b0;
      end else if (dro_en & at_last_tap) begin
         ckstp_r <= 1'b1;
      end
   end

   // open-drain: enable low pulls the pin down
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_checkstop_out_n_o    <= 1'b0;
         o_checkstop_out_n_oe_n <= 1'b1;
      end else begin
         o_checkstop_out_n_o    <= 1'b0;
         o_checkstop_out_n_oe_n <= ~(dro_en & at_last_tap) & ~ckstp_r;
      end
   end

   // retry pin low while hard reset is held selects the no-retry mode;
   // the last value seen before hard reset rises is kept
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_no_data_retry_mode <= 1'b0;
      end else if (!hard_reset_n_s) begin
         o_no_data_retry_mode <= ~dretry_s;
      end
   end

   // pin receivers and drivers
   wire        rx_data   = i_read_active;
   wire [31:0] low_drv   = bus32 ? 32'h0000_0000 : i_data_low_src;
   wire [7:0]  par_drv   = bus32 ? {i_data_parity_src[7:4], 4'h0}
                                 : i_data_parity_src;
   wire [7:0]  par_rx    = {4'hF, {4{~bus32}}} & {8{dpchk & rx_data}};

   // pin data and enables are registered so every pin leaves a flop;
   // the drive enable is the bus unit's, this block only zeroes lanes
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_data_high_o    <= 32'h0000_0000;
         o_data_low_o     <= 32'h0000_0000;
         o_data_parity_o  <= 8'h00;
         o_data_high_oe_n <= 1'b1;
         o_data_low_oe_n  <= 1'b1;
      end else begin
         o_data_high_o    <= i_data_high_src;
         o_data_low_o     <= low_drv;
         o_data_parity_o  <= par_drv;
         o_data_high_oe_n <= ~i_drive_en;
         o_data_low_oe_n  <= ~i_drive_en;
      end
   end

   // receivers off by default; an idle floating bus then draws no current
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_data_high_rx_en   <= 1'b0;
         o_data_low_rx_en    <= 1'b0;
         o_data_parity_rx_en <= 8'h00;
         o_addr_parity_rx_en <= 1'b0;
      end else begin
         o_data_high_rx_en   <= rx_data;
         o_data_low_rx_en    <= rx_data & ~bus32;
         o_data_parity_rx_en <= par_rx;
         o_addr_parity_rx_en <= apchk;
      end
   end

   // snoop receivers must stay on even with the address bus floating
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_snoop_rx_en      <= 1'b0;
         o_cache_enable_bit <= 1'b0;
      end else begin
         o_snoop_rx_en      <= 1'b1;
         o_cache_enable_bit <= l2_on;
      end
   end
endmodule

// >>> test/lcdc_properties.sv
// port-level checker for the cache/dll clock control block
// assumes it is bound to lcdc_top and sees only its ports
module lcdc_properties (
   input wire logic        i_core_clk,
   input wire logic        i_rst_n,
   input wire logic        i_rd,
   input wire logic [31:0] o_rdata,
   input wire logic        i_acc_valid,
   input wire logic        i_acc_data,
   input wire logic        i_acc_hit,
   input wire logic        o_acc_valid,
   input wire logic        o_acc_use_cache,
   input wire logic        o_acc_allocate,
   input wire logic        o_acc_inhibit,
   input wire logic        i_dll_clk,
   input wire logic [6:0]  i_dll_tap_counter,
   input wire logic        o_dll_feedback_path,
   input wire logic        o_sram_clock_out,
   input wire logic        o_sram_sleep_pin,
   input wire logic        o_checkstop_out_n_o,
   input wire logic        o_checkstop_out_n_oe_n,
   input wire logic        i_read_active,
   input wire logic        o_data_high_rx_en,
   input wire logic        o_data_low_rx_en,
   input wire logic [7:0]  o_data_parity_rx_en,
   input wire logic        o_snoop_rx_en
);
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (!i_rst_n);
   // edges since reset release; the clock path needs three to fill
   logic [2:0] up_r;
   always_ff @(posedge i_core_clk or negedge i_rst_n)
      if (!i_rst_n) up_r <= '0;
      else if (up_r != 3'h7) up_r <= up_r + 3'h1;
   a_fb_follows: assert property (up_r == 3'h7 |->
      o_dll_feedback_path == $past(i_dll_clk, 3)) else $error("fb stuck");
   a_gate_only_sram: assert property (o_sram_clock_out |->
      o_dll_feedback_path) else $error("sram clock off phase");
   a_ckstp_sticky: assert property (!o_checkstop_out_n_oe_n |=>
      !o_checkstop_out_n_oe_n) else $error("checkstop released");
   a_ckstp_od: assert property (o_checkstop_out_n_o == 1'b0)
      else $error("checkstop drives high");
   a_ckstp_cause: assert property ($fell(o_checkstop_out_n_oe_n) |->
      $past(i_dll_tap_counter, 3) == 7'h7F) else $error("bad checkstop");
   a_snoop_on: assert property ($past(i_rst_n) |-> o_snoop_rx_en)
      else $error("snoop receivers off");
   a_data_rx_off: assert property (!$past(i_read_active) |->
      !o_data_high_rx_en && !o_data_low_rx_en &&
      o_data_parity_rx_en == 8'h00) else $error("data rx on, no read");
   a_inhibit_cause: assert property (o_acc_inhibit |->
      $past(i_acc_valid && i_acc_data && !i_acc_hit))
      else $error("bad inhibit");
   a_alloc_miss: assert property (o_acc_allocate |->
      $past(i_acc_valid && !i_acc_hit) && !o_acc_inhibit)
      else $error("bad allocate");
   a_hit_serviced: assert property (o_acc_use_cache |->
      $past(i_acc_hit) && o_acc_valid) else $error("bad use");
   a_rdata_idle: assert property (!$past(i_rd) |->
      o_rdata == '0) else $error("read data outside slot");
   c_ckstp: cover property ($fell(o_checkstop_out_n_oe_n));
   c_inhibit: cover property (o_acc_inhibit);
   c_sleep: cover property ($rose(o_sram_sleep_pin));
endmodule
bind lcdc_top lcdc_properties lcdc_properties_i (.*);

// >>> test/lcdc_far_model.sv
// far side: free-running dll clock, dll tap value, reset and retry straps
// assumes the bench picks the tap value the dll should report
module lcdc_far_model (
   input  wire logic [6:0] i_tap_set,
   output logic            o_dll_clk,
   output logic [6:0]      o_tap,
   output logic            o_hard_reset_n,
   output logic            o_data_retry_n
);
   timeunit 1ns;
   timeprecision 100ps;
   // dll loop runs free, so no idle gap in its clock
   initial o_dll_clk = 1'b0;
   always #80 o_dll_clk = ~o_dll_clk;
   // tap moves off the core clock grid, as a real loop would
   assign #7 o_tap = i_tap_set;
   initial begin
      o_hard_reset_n = 1'b0;
      #100 o_hard_reset_n = 1'b1;
   end
   // no data retry in this system: strap follows hard reset
   assign o_data_retry_n = o_hard_reset_n;
endmodule

// >>> test/test_lcdc_top.sv
// self-checking bench for the cache/dll clock control block
// assumes the far model supplies dll clock, tap value and straps
module test_lcdc_top;
   timeunit 1ns;
   timeprecision 100ps;
   import lcdc_pkg::*;
   logic        i_core_clk = 0, i_rst_n = 0, i_wr = 0, i_rd = 0;
   logic [7:0]  i_addr = '0, o_data_parity_o, o_data_parity_rx_en;
   logic [31:0] i_wdata = '0, o_rdata, o_data_high_o, o_data_low_o;
   logic        i_nap_sleep = 0, i_snoop_wake = 0, i_acc_valid = 0;
   logic        i_acc_data = 0, i_acc_write = 0, i_acc_hit = 0;
   logic        o_acc_valid, o_acc_use_cache, o_acc_allocate;
   logic        o_acc_inhibit, i_dll_clk, o_sram_clock_out;
   logic        o_dll_feedback_path, o_sram_sleep_pin;
   logic        o_checkstop_out_n_o, o_checkstop_out_n_oe_n;
   logic        i_hard_reset_n, i_data_retry_n, o_no_data_retry_mode;
   logic        i_read_active = 0, i_drive_en = 0, o_cache_enable_bit;
   logic [31:0] i_data_high_src = '1, i_data_low_src = '1;
   logic [7:0]  i_data_parity_src = '1;
   logic        o_data_high_oe_n, o_data_low_oe_n, o_data_high_rx_en;
   logic        o_data_low_rx_en, o_addr_parity_rx_en, o_snoop_rx_en;
   logic [6:0]  i_dll_tap_counter, tap_set = 7'h15;
   int          errors = 0, check_count = 0;
   always #2 i_core_clk = ~i_core_clk;
   lcdc_top lcdc_top_i (.*);
   lcdc_far_model lcdc_far_model_i (
      .i_tap_set      (tap_set),
      .o_dll_clk      (i_dll_clk),
      .o_tap          (i_dll_tap_counter),
      .o_hard_reset_n (i_hard_reset_n),
      .o_data_retry_n (i_data_retry_n));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge i_core_clk);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge i_core_clk);
      i_wr    <= 1'b1;
      i_addr  <= a;
      i_wdata <= d;
      @(posedge i_core_clk);
      i_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge i_core_clk);
      i_rd   <= 1'b1;
      i_addr <= a;
      @(posedge i_core_clk);
      i_rd <= 1'b0;
      #1 d = o_rdata;
   endtask
   task automatic t_regs;
      logic [31:0] a, b;
      rd(OFF_CTRL, a);
      chk(a, CTRL_RESET | (32'(tap_set) << CTRL_TAP_LSB));
      wr(OFF_CTRL, 32'hFFFF_FFFF);
      rd(OFF_CTRL, a);
      rd(OFF_CTRL, b);
      chk(a, b);
      chk(a, CTRL_WR_MASK | (32'(tap_set) << CTRL_TAP_LSB));
      chk(32'(o_cache_enable_bit), 32'h1);
      rd(8'h0C, a);
      chk(a, 32'h0);
      rd(OFF_STATUS, a);
      chk(a, 32'h2);
      chk(32'(o_no_data_retry_mode), 32'h1);
      $display("regs done");
   endtask
   task automatic acc(input logic d, w, h, input logic [2:0] e);
      @(posedge i_core_clk);
      i_acc_valid <= 1'b1;
      i_acc_data  <= d;
      i_acc_write <= w;
      i_acc_hit   <= h;
      @(posedge i_core_clk);
      i_acc_valid <= 1'b0;
      #1 chk(32'({o_acc_valid, o_acc_use_cache, o_acc_allocate,
                  o_acc_inhibit}), 32'({1'b1, e}));
   endtask
   task automatic t_acc;
      wr(OFF_CTRL, 32'h0000_0400);
      acc(1, 0, 0, 3'b000);
      wr(OFF_CTRL, 32'h8000_0400);
      acc(1, 1, 1, 3'b100);
      acc(1, 0, 0, 3'b001);
      acc(0, 0, 0, 3'b010);
      wr(OFF_CTRL, 32'h8040_0400);
      acc(0, 0, 0, 3'b000);
      acc(1, 1, 1, 3'b100);
      wr(OFF_CTRL, 32'h8000_0000);
      acc(1, 0, 0, 3'b010);
      $display("access done");
   endtask
   // counts high samples of both clock outputs over 100 core cycles
   task automatic cnt(output int s, output int f);
      s = 0;
      f = 0;
      repeat (100) begin
         cyc(1);
         s += o_sram_clock_out;
         f += o_dll_feedback_path;
      end
   endtask
   task automatic t_power;
      int s, f;
      wr(OFF_CTRL, 32'h8000_0200);
      i_nap_sleep <= 1'b1;
      cyc(4);
      cnt(s, f);
      chk(32'(s), 32'h0);
      chk(32'(f > 20), 32'h1);
      @(posedge i_core_clk);
      i_snoop_wake <= 1'b1;
      cyc(4);
      cnt(s, f);
      chk(32'(s > 20), 32'h1);
      @(posedge i_core_clk);
      i_snoop_wake <= 1'b0;
      i_nap_sleep  <= 1'b0;
      cyc(4);
      cnt(s, f);
      chk(32'(s > 20), 32'h1);
      wr(OFF_CTRL, 32'h8010_0000);
      i_nap_sleep <= 1'b1;
      cyc(3);
      chk(32'(o_sram_sleep_pin), 32'h1);
      @(posedge i_core_clk);
      i_nap_sleep <= 1'b0;
      cyc(3);
      chk(32'(o_sram_sleep_pin), 32'h0);
      $display("power done");
   endtask
   task automatic pins(input logic [31:0] c, input logic r,
                       input logic [10:0] e);
      wr(OFF_CONFIG, c);
      i_read_active <= r;
      i_drive_en    <= 1'b1;
      cyc(3);
      chk(32'({o_data_high_rx_en, o_data_low_rx_en, o_addr_parity_rx_en,
               o_data_parity_rx_en}), 32'(e));
   endtask
   task automatic t_pins;
      pins(32'h6, 1'b1, 11'h7FF);
      chk(o_data_low_o, 32'hFFFF_FFFF);
      chk(o_data_high_o, 32'hFFFF_FFFF);
      chk(32'({o_data_high_oe_n, o_data_low_oe_n}), 32'h0);
      pins(32'h7, 1'b1, 11'h5F0);
      chk(o_data_low_o, 32'h0);
      chk(32'(o_data_parity_o), 32'hF0);
      pins(32'h8, 1'b1, 11'h600);
      pins(32'h6, 1'b0, 11'h100);
      chk(32'(o_snoop_rx_en), 32'h1);
      $display("pins done");
   endtask
   task automatic t_inval;
      logic [31:0] a;
      int n;
      wr(OFF_CONFIG, 32'h10);
      rd(OFF_CTRL, a);
      chk(32'(a[CTRL_IP_BIT]), 32'h1);
      n = 0;
      do begin
         rd(OFF_CTRL, a);
         n++;
      end while (a[CTRL_IP_BIT] && n < 800);
      chk(32'(n > 480 && n < 530), 32'h1);
      $display("invalidate done");
   endtask
   task automatic t_dro;
      logic [31:0] a;
      wr(OFF_CTRL, 32'h8000_0000);
      tap_set <= TAP_LAST;
      cyc(10);
      chk(32'(o_checkstop_out_n_oe_n), 32'h1);
      // armed while the tap already sits at the last value
      wr(OFF_CTRL, 32'h8000_0100);
      cyc(4);
      chk(32'(o_checkstop_out_n_oe_n), 32'h0);
      tap_set <= 7'h20;
      cyc(10);
      chk(32'(o_checkstop_out_n_oe_n), 32'h0);
      rd(OFF_STATUS, a);
      chk(a & 32'h1, 32'h1);
      $display("rollover done");
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      repeat (12) @(posedge i_core_clk);
      i_rst_n <= 1'b1;
      cyc(4);
      t_regs;
      t_acc;
      t_power;
      t_pins;
      t_inval;
      // checkstop is sticky to reset, so it goes last
      t_dro;
      summarize;
   end
   initial begin
      #40000;
      errors++;
      summarize;
   end
endmodule
